// ==== core/iab_ack_core.sv ====
// acknowledge slot, bit count and address recognition of a two-wire port
// assumes: bus start/stop detect and sda sampling done on clk_link;
// config bits change only between frames (they cross as quasi-static)
//
// Summary of operation
// - slave with nack reply ignores own and general-call addresses, no irq
// - as master the nack reply select bit has no effect
// - clearing nack select in a slave transfer reads 1, current byte acked
// - master in ack mode adds one clock pulse after each unit
// - slave in ack mode counts the ack pulse in the unit's pulses
// - transmitter releases data line during the ack pulse
// - receiver holds data line low during the ack pulse
// - slave acks a general-call address in ack mode
// - master in non-ack mode gives no ack clock pulse
// - slave in non-ack mode counts no ack pulse
// - transfer width sets the bit count of the next unit
// - start condition forces transfer width to 000, eight-bit address unit
// - otherwise transfer width keeps the value last written
// - in address format a slave compares the first byte to the own address
// - free format skips address recognition
// - in free format bits after start are plain data
`timescale 1ns/100ps
module iab_ack_core (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_link,
    input  wire logic       nackWrStb,
    input  wire logic       nackWrVal,
    input  wire logic       widthWrStb,
    input  wire logic [2:0] widthWrVal,
    input  wire logic       ackModeSel,
    input  wire logic       freeFormatSel,
    input  wire logic [6:0] ownSlaveAddress,
    input  wire logic       masterSel,
    input  wire logic       transmitSel,
    input  wire logic [7:0] txData,
    output logic            nackReplySelect,
    output logic      [2:0] transferWidth,
    output logic            serialBusIrq,
    output logic      [7:0] rxData,
    output logic            addrMatch,
    output logic            generalCall,
    output logic      [3:0] unitPulses,
    output logic            slaveBusy,
    input  wire logic       busStart,
    input  wire logic       busStop,
    input  wire logic       serialDataIn,
    output logic            serialClockGate,
    output logic            serialDataPinOut,
    output logic            serialDataPinOe
);
    // ------------------------------------------------------------
    // link reset release and domain crossings
    // ------------------------------------------------------------
    logic [1:0]                 lnkRst_ff;
    logic                       lnkRstN;
    logic [iab_pkg::CFG_W-1:0]  cfgSys;
    logic [iab_pkg::CFG_W-1:0]  cfgL;
    logic [iab_pkg::STS_W-1:0]  stsL;
    logic [iab_pkg::STS_W-1:0]  stsS;
    logic                       nackReg_ff;
    logic                       nackClrPend_ff;
    logic [2:0]                 width_ff;

    // reset released in step with the link clock
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            lnkRst_ff <= 2'h0;
        end else begin
            lnkRst_ff <= {lnkRst_ff[0], 1'b1};
        end
    end
    assign lnkRstN = lnkRst_ff[1];

    // pending clear lets the link ack the current byte
    assign cfgSys = {txData, ownSlaveAddress, width_ff, transmitSel, masterSel,
                     freeFormatSel, ackModeSel, nackReg_ff & ~nackClrPend_ff};

    iab_sync #(.W(iab_pkg::CFG_W)) u_cfg_sync (
        .clk   (clk_link),
        .rst_n (lnkRstN),
        .d     (cfgSys),
        .q     (cfgL)
    );

    iab_sync #(.W(iab_pkg::STS_W)) u_sts_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (stsL),
        .q     (stsS)
    );

    // ------------------------------------------------------------
    // link domain decode
    // ------------------------------------------------------------
    iab_pkg::iab_state_t lnkState_ff;
    iab_pkg::iab_state_t nxt_lnkState;
    logic [3:0] lnkBitCnt_ff;
    logic [3:0] lnkPulseCnt_ff;
    logic [3:0] lnkPulses_ff;
    logic [7:0] lnkRxShift_ff;
    logic [7:0] lnkRxWord_ff;
    logic       lnkFirst_ff;
    logic       lnkSel_ff;
    logic       lnkSlvTx_ff;
    logic       lnkUnitIrq_ff;
    logic       lnkHit_ff;
    logic       lnkGc_ff;
    logic       lnkIrqTog_ff;
    logic       lnkStartTog_ff;
    logic       lnkBusy_ff;
    logic       lnkSdaOe_ff;
    logic       lnkSclGate_ff;

    wire       lnkNack   = cfgL[iab_pkg::CFG_NACK];
    wire       ackModeL  = cfgL[iab_pkg::CFG_ACKM];
    wire       freeL     = cfgL[iab_pkg::CFG_FREE];
    wire       masterL   = cfgL[iab_pkg::CFG_MST];
    wire       txL       = cfgL[iab_pkg::CFG_TX];
    wire [2:0] widthL    = cfgL[iab_pkg::CFG_WID_LSB +: 3];
    wire [6:0] ownAdrL   = cfgL[iab_pkg::CFG_ADR_LSB +: 7];
    wire [7:0] txDataL   = cfgL[iab_pkg::CFG_TXD_LSB +: 8];
    wire       inData    = (lnkState_ff == iab_pkg::ST_DATA);
    wire       inAck     = (lnkState_ff == iab_pkg::ST_ACK);

    // width 000 means a full unit; first unit after start is always full
    wire [3:0] cfgBits   = (widthL == 3'h0) ? iab_pkg::FULL_UNIT_BITS : {1'b0, widthL};
    wire [3:0] unitBits  = lnkFirst_ff ? iab_pkg::FULL_UNIT_BITS : cfgBits;
    wire       lastBit   = inData && (lnkBitCnt_ff == unitBits - 4'h1);
    wire       unitEnd   = ackModeL ? inAck : lastBit;
    wire [7:0] rxNext    = {lnkRxShift_ff[6:0], serialDataIn};

    // address only for slaves in address format
    wire       isAddrUnit = lnkFirst_ff && !freeL && !masterL;
    wire       ownHit     = (rxNext[7:1] == ownAdrL);
    wire       gcHit      = (rxNext[7:1] == iab_pkg::GEN_CALL_ADDR);
    wire       addrAck    = (ownHit || gcHit) && !lnkNack;
    wire       involved   = masterL || freeL || lnkSel_ff;
    wire       txRole     = (masterL || freeL) ? txL : (lnkSel_ff && lnkSlvTx_ff);
    wire       ackDrive   = isAddrUnit ? addrAck : (involved && !txRole);
    wire       unitIrqNow = isAddrUnit ? addrAck : involved;
    wire       irqFire    = unitEnd && (inAck ? lnkUnitIrq_ff : unitIrqNow);
    wire [3:0] expPulses  = unitBits + {3'h0, ackModeL};

    // next state of the bit engine
    assign nxt_lnkState = busStop                ? iab_pkg::ST_IDLE :
                          busStart               ? iab_pkg::ST_DATA :
                          (lastBit && ackModeL)  ? iab_pkg::ST_ACK  :
                          inAck                  ? iab_pkg::ST_DATA :
                          lnkState_ff;

    wire [3:0] nxtBitCnt  = (busStart || unitEnd) ? 4'h0 :
                            inData ? lnkBitCnt_ff + 4'h1 : lnkBitCnt_ff;
    wire       nxtFirst   = busStart ? 1'b1 : (unitEnd ? 1'b0 : lnkFirst_ff);
    wire [3:0] nxtBits    = nxtFirst ? iab_pkg::FULL_UNIT_BITS : cfgBits;
    wire [3:0] txIdx4     = nxtBits - 4'h1 - nxtBitCnt;
    wire       txBit      = txDataL[txIdx4[2:0]];
    wire       txNext     = txRole && !(busStart && !masterL);
    // open-drain data: enable pulls low
    wire       nxtSdaOe   = (nxt_lnkState == iab_pkg::ST_ACK)  ? ackDrive :
                            (nxt_lnkState == iab_pkg::ST_DATA) ? (txNext && !txBit) : 1'b0;
    // master emits one pulse per slot, ack slot only in ack mode
    wire       nxtSclGate = masterL && (nxt_lnkState != iab_pkg::ST_IDLE);
    wire       nxtSel     = (busStart || busStop) ? (freeL && !busStop) :
                            (lastBit && isAddrUnit) ? addrAck : lnkSel_ff;
    // slave pulse count: ack slot counted only when it exists
    wire [3:0] nxtPulseCnt = (busStart || unitEnd) ? 4'h0 :
                             (inData || inAck) ? lnkPulseCnt_ff + 4'h1 : lnkPulseCnt_ff;

    // ------------------------------------------------------------
    // link domain registers
    // ------------------------------------------------------------
    // bit engine state
    always_ff @(posedge clk_link or negedge lnkRstN) begin
        if (!lnkRstN) begin
            lnkState_ff    <= iab_pkg::ST_IDLE;
            lnkBitCnt_ff   <= 4'h0;
            lnkPulseCnt_ff <= 4'h0;
            lnkFirst_ff    <= 1'b0;
            lnkSel_ff      <= 1'b0;
            lnkSdaOe_ff    <= 1'b0;
            lnkSclGate_ff  <= 1'b0;
            lnkRxShift_ff  <= 8'h00;
        end else begin
            lnkState_ff    <= nxt_lnkState;
            lnkBitCnt_ff   <= nxtBitCnt;
            lnkPulseCnt_ff <= nxtPulseCnt;
            lnkFirst_ff    <= nxtFirst;
            lnkSel_ff      <= nxtSel;
            lnkSdaOe_ff    <= nxtSdaOe;
            lnkSclGate_ff  <= nxtSclGate;
            lnkRxShift_ff  <= inData ? rxNext : lnkRxShift_ff;
        end
    end

    // unit results captured for the system side
    always_ff @(posedge clk_link or negedge lnkRstN) begin
        if (!lnkRstN) begin
            lnkRxWord_ff   <= 8'h00;
            lnkPulses_ff   <= 4'h0;
            lnkUnitIrq_ff  <= 1'b0;
            lnkHit_ff      <= 1'b0;
            lnkGc_ff       <= 1'b0;
            lnkSlvTx_ff    <= 1'b0;
            lnkIrqTog_ff   <= 1'b0;
            lnkStartTog_ff <= 1'b0;
            lnkBusy_ff     <= 1'b0;
        end else begin
            lnkRxWord_ff   <= lastBit ? rxNext : lnkRxWord_ff;
            lnkPulses_ff   <= unitEnd ? lnkPulseCnt_ff + 4'h1
                                      : lnkPulses_ff;
            lnkUnitIrq_ff  <= lastBit ? unitIrqNow : lnkUnitIrq_ff;
            lnkHit_ff      <= (lastBit && isAddrUnit) ? (ownHit && addrAck) : lnkHit_ff;
            lnkGc_ff       <= (lastBit && isAddrUnit) ? (gcHit && addrAck) : lnkGc_ff;
            lnkSlvTx_ff    <= (lastBit && isAddrUnit) ? rxNext[0] : lnkSlvTx_ff;
            lnkIrqTog_ff   <= lnkIrqTog_ff ^ irqFire;
            lnkStartTog_ff <= lnkStartTog_ff ^ busStart;
            lnkBusy_ff     <= !masterL && nxtSel && (nxt_lnkState != iab_pkg::ST_IDLE);
        end
    end

    assign stsL = {lnkBusy_ff, lnkStartTog_ff, lnkIrqTog_ff};

    // ------------------------------------------------------------
    // system domain control bits and results
    // ------------------------------------------------------------
    logic       irqSeen_ff;
    logic       startSeen_ff;
    logic       irq_ff;
    logic [7:0] rxData_ff;
    logic       addrMatch_ff;
    logic       gc_ff;
    logic [3:0] pulses_ff;
    logic       busy_ff;

    wire irqEvt   = stsS[iab_pkg::STS_IRQ] ^ irqSeen_ff;
    wire startEvt = stsS[iab_pkg::STS_START] ^ startSeen_ff;
    wire busyS    = stsS[iab_pkg::STS_BUSY];
    // write of 0 in a slave transfer only arms a pending clear
    wire clrNow   = nackWrStb && !nackWrVal && !busyS;
    wire clrDefer = nackWrStb && !nackWrVal && busyS && nackReg_ff;
    wire nxtNack  = (nackWrStb && nackWrVal) ? 1'b1 :
                    (clrNow || (nackClrPend_ff && !busyS)) ? 1'b0 : nackReg_ff;
    wire nxtPend  = (nackWrStb && nackWrVal) ? 1'b0 :
                    clrDefer ? 1'b1 : (nackClrPend_ff && busyS);
    // start forces width to 000, otherwise last write holds
    wire [2:0] nxtWidth = startEvt   ? iab_pkg::WIDTH_ON_START :
                          widthWrStb ? widthWrVal : width_ff;

    // control bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nackReg_ff     <= iab_pkg::NACK_RST;
            nackClrPend_ff <= 1'b0;
            width_ff       <= iab_pkg::WIDTH_RST;
            irqSeen_ff     <= 1'b0;
            startSeen_ff   <= 1'b0;
            busy_ff        <= 1'b0;
        end else begin
            nackReg_ff     <= nxtNack;
            nackClrPend_ff <= nxtPend;
            width_ff       <= nxtWidth;
            irqSeen_ff     <= stsS[iab_pkg::STS_IRQ];
            startSeen_ff   <= stsS[iab_pkg::STS_START];
            busy_ff        <= busyS;
        end
    end

    // results, copied when a unit event arrives
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff       <= 1'b0;
            rxData_ff    <= 8'h00;
            addrMatch_ff <= 1'b0;
            gc_ff        <= 1'b0;
            pulses_ff    <= 4'h0;
        end else begin
            irq_ff       <= irqEvt;
            rxData_ff    <= irqEvt ? lnkRxWord_ff : rxData_ff;
            addrMatch_ff <= irqEvt ? lnkHit_ff : addrMatch_ff;
            gc_ff        <= irqEvt ? lnkGc_ff : gc_ff;
            pulses_ff    <= irqEvt ? lnkPulses_ff : pulses_ff;
        end
    end

    assign nackReplySelect  = nackReg_ff;
    assign transferWidth    = width_ff;
    assign serialBusIrq     = irq_ff;
    assign rxData           = rxData_ff;
    assign addrMatch        = addrMatch_ff;
    assign generalCall      = gc_ff;
    assign unitPulses       = pulses_ff;
    assign slaveBusy        = busy_ff;
    assign serialClockGate  = lnkSclGate_ff;
    assign serialDataPinOut = 1'b0;
    assign serialDataPinOe  = lnkSdaOe_ff;

    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    nack_addr_quiet_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && isAddrUnit && lnkNack && !busStart && !busStop |=> !lnkSdaOe_ff)
        else $error("nack reply slave drove ack on address");
    master_ack_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && masterL && ackModeL && !txL && !busStart && !busStop
        |=> inAck && lnkSdaOe_ff)
        else $error("master receiver did not ack");
    nack_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clrDefer |=> nackReg_ff && nackClrPend_ff)
        else $error("nack select cleared during slave transfer");
    ack_pulse_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && masterL && ackModeL && !busStart && !busStop |=> inAck && lnkSclGate_ff)
        else $error("master gave no ack clock pulse");
    pulse_count_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        unitEnd && !masterL && !busStart |=> lnkPulses_ff == $past(expPulses))
        else $error("slave pulse count wrong");
    tx_release_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && ackModeL && txRole && !isAddrUnit && !busStart && !busStop
        |=> inAck && !lnkSdaOe_ff)
        else $error("transmitter held data line in ack slot");
    gen_call_ack_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && isAddrUnit && gcHit && !lnkNack && ackModeL && !busStart && !busStop
        |=> lnkSdaOe_ff)
        else $error("general call not acked");
    no_ack_slot_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && !ackModeL && !busStart && !busStop |=> inData && lnkBitCnt_ff == 4'h0)
        else $error("ack slot present in non-ack mode");
    width_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        startEvt |=> transferWidth == iab_pkg::WIDTH_ON_START)
        else $error("width not cleared on start");
    width_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !startEvt && !widthWrStb |=> $stable(width_ff))
        else $error("width changed without a write");
    free_data_a: assert property (@(posedge clk_link) disable iff (!lnkRstN)
        lastBit && lnkFirst_ff && freeL && !masterL && ackModeL && !txL && !busStart && !busStop
        |=> lnkSdaOe_ff)
        else $error("free format first unit not taken as data");

    own_addr_c: cover property (@(posedge clk_link) lastBit && isAddrUnit && ownHit && addrAck);
    gen_call_c: cover property (@(posedge clk_link) lastBit && isAddrUnit && gcHit && addrAck);
    nack_defer_c: cover property (@(posedge clk_sys) clrDefer ##[1:200] !nackClrPend_ff);
endmodule

// ==== core/iab_pkg.sv ====
// package of shared constants for the acknowledge / bit-count / address block
// assumes: included before iab_sync and iab_ack_core
package iab_pkg;
    // ------------------------------------------------------------
    // reset values and fixed codes
    // ------------------------------------------------------------
    localparam logic       NACK_RST       = 1'b0;
    localparam logic [2:0] WIDTH_RST      = 3'h0;
    localparam logic [2:0] WIDTH_ON_START = 3'h0;
    localparam logic [3:0] FULL_UNIT_BITS = 4'h8;
    localparam logic [6:0] GEN_CALL_ADDR  = 7'h00;

    // ------------------------------------------------------------
    // layout of config vector crossing into link domain
    // ------------------------------------------------------------
    localparam int CFG_W       = 23;
    localparam int CFG_NACK    = 0;
    localparam int CFG_ACKM    = 1;
    localparam int CFG_FREE    = 2;
    localparam int CFG_MST     = 3;
    localparam int CFG_TX      = 4;
    localparam int CFG_WID_LSB = 5;
    localparam int CFG_ADR_LSB = 8;
    localparam int CFG_TXD_LSB = 15;

    // layout of status vector crossing into system domain
    localparam int STS_W      = 3;
    localparam int STS_IRQ    = 0;
    localparam int STS_START  = 1;
    localparam int STS_BUSY   = 2;

    // link engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_ACK  = 2'b10
    } iab_state_t;
endpackage

// ==== core/iab_sync.sv ====
// two-stage level synchroniser, width set by parameter
// assumes: d is quasi-static or a toggle; q read only in the clk domain
`timescale 1ns/100ps
module iab_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= d;
            hold_ff <= meta_ff;
        end
    end

    assign q = hold_ff;
endmodule

// ==== verif/iab_ack_core_tb.sv ====
// self-checking bench for the ack, bit count and address block
// assumes: iab_pkg, iab_ack_core and iab_bus_partner compiled before it
`timescale 1ns/100ps
module iab_ack_core_tb;
    localparam logic [7:0] OWN_WR = 8'hb4; // own address 5a, direction 0
    logic [6:0] ownAdr = OWN_WR[7:1];
    logic       clk_sys = 1'b0, clk_link = 1'b0, rst_n = 1'b0, ack;
    logic       nackWrStb = 1'b0, nackWrVal = 1'b0, widthWrStb = 1'b0;
    logic [2:0] widthWrVal = 3'h0;
    logic       ackModeSel = 1'b1; // ack mode kept for address units
    logic       freeFormatSel = 1'b0, masterSel = 1'b0, transmitSel = 1'b0;
    logic       gateCountEn = 1'b0;
    logic [7:0] txData = 8'ha5, rxData;
    logic       nackReplySelect, serialBusIrq, addrMatch, generalCall, slaveBusy;
    logic       serialClockGate, serialDataPinOe, busStart, busStop, serialDataIn;
    logic [2:0] transferWidth;
    logic [3:0] unitPulses;
    int         gateCount = 0, irqCount = 0, base = 0, mismatches = 0, comparisons = 0;

    always #2.5 clk_sys = ~clk_sys;
    always #24 clk_link = ~clk_link;
    // irq pulses and master clock slots seen
    always @(negedge clk_sys) if (serialBusIrq === 1'b1) irqCount++;
    always @(negedge clk_link) if (gateCountEn && serialClockGate === 1'b1) gateCount++;

    iab_ack_core i_dut (
        .clk_sys, .rst_n, .clk_link, .nackWrStb, .nackWrVal, .widthWrStb, .widthWrVal,
        .ackModeSel, .freeFormatSel, .ownSlaveAddress(ownAdr), .masterSel,
        .transmitSel, .txData, .nackReplySelect, .transferWidth, .serialBusIrq, .rxData,
        .addrMatch, .generalCall, .unitPulses, .slaveBusy, .busStart, .busStop,
        .serialDataIn, .serialClockGate, .serialDataPinOut(), .serialDataPinOe
    );
    iab_bus_partner i_partner (
        .clk_link, .serialDataPinOe, .busStart, .busStop, .serialDataIn
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s %h, want %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one-cycle strobe on nack select or transfer width
    task automatic wr_reg(input logic isNack, input logic [2:0] v);
        @(negedge clk_sys);
        {nackWrStb, widthWrStb, nackWrVal, widthWrVal} = {isNack, ~isNack, v[0], v};
        @(negedge clk_sys);
        {nackWrStb, widthWrStb} = 2'b00;
    endtask
    // irq total reaches n within a bound, and no extra one follows
    task automatic wait_irq(input int n);
        for (int i = 0; i < 80 && irqCount < n; i++) @(negedge clk_sys);
        repeat (20) @(negedge clk_sys);
        check(8'(irqCount), 8'(n), "irq count");
        if (irqCount < n) conclude();
    endtask
    task automatic unit(input logic [7:0] d, input int n, input logic expAck);
        i_partner.send_unit(d, n, 1'b1, ack);
        check(8'(ack), 8'(expAck), "ack slot");
    endtask

    task automatic t_addressed();
        wr_reg(1'b0, 3'h3);
        check(8'(transferWidth), 8'h03, "width written");
        base = irqCount;
        i_partner.pulse(1'b0);
        fork
            unit(OWN_WR, 8, 1'b1);
            begin
                repeat (20) @(negedge clk_sys);
                check(8'(transferWidth), 8'(iab_pkg::WIDTH_ON_START), "start width");
                wr_reg(1'b0, 3'h4);
            end
        join
        unit(8'h0b, 4, 1'b1);
        i_partner.pulse(1'b1);
        wait_irq(base + 2);
        check(rxData & 8'h0f, 8'h0b, "four-bit unit");
        check(8'(unitPulses), 8'h05, "pulses with ack slot");
        check(8'(addrMatch), 8'h01, "address match");
        check(8'(transferWidth), 8'h04, "width kept");
        $display("addressed receive done");
    endtask
    task automatic t_busy();
        base = irqCount;
        i_partner.pulse(1'b0);
        unit(OWN_WR, 8, 1'b1);
        fork
            unit(8'h96, 8, 1'b1);
            begin
                for (int i = 0; i < 40 && slaveBusy !== 1'b1; i++) @(negedge clk_sys);
                check(8'(slaveBusy), 8'h01, "slave busy");
                wr_reg(1'b1, 3'h1);
                wr_reg(1'b1, 3'h0);
                check(8'(nackReplySelect), 8'h01, "nack held");
            end
        join
        i_partner.pulse(1'b1);
        wait_irq(base + 2);
        check(8'(nackReplySelect), 8'h00, "held clear applied");
        $display("nack clear in transfer done");
    endtask
    // foreign, general call, then own and general call with nack reply
    task automatic t_others();
        for (int i = 0; i < 4; i++) begin
            ownAdr = (i == 0) ? 7'h5b : OWN_WR[7:1]; // own address moved away for the foreign one
            if (i == 2)
                wr_reg(1'b1, 3'h1);
            base = irqCount;
            i_partner.pulse(1'b0);
            unit(i[0] ? {iab_pkg::GEN_CALL_ADDR, 1'b0} : OWN_WR, 8,
                 i == 1);
            if (i == 1)
                unit(8'h06, 8, 1'b1);
            i_partner.pulse(1'b1);
            wait_irq(base + 2 * (i == 1));
            if (i == 1)
                check(8'(generalCall), 8'h01, "general call");
        end
        $display("foreign and refused addresses done");
    endtask
    // free format slave receive, ack mode then non-ack mode
    task automatic t_free();
        for (int i = 0; i < 2; i++) begin
            @(negedge clk_sys);
            {ackModeSel, freeFormatSel, masterSel, transmitSel} = {i == 0, 3'b100};
            repeat (4) @(negedge clk_link);
            base = irqCount;
            i_partner.pulse(1'b0);
            i_partner.send_unit(8'h3c, 8, i == 0, ack);
            i_partner.pulse(1'b1);
            wait_irq(base + 1);
            check(8'(ack), 8'(i == 0), "free ack");
            check(rxData, 8'h3c, "free data");
            check(8'(unitPulses), 8'(iab_pkg::FULL_UNIT_BITS + (i == 0)), "pulses");
        end
        $display("free format done");
    endtask
    // master frames with nack select still set: tx ack, tx non-ack, rx ack
    task automatic t_master();
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            {ackModeSel, freeFormatSel, masterSel, transmitSel} = {i != 1, 2'b01, i != 2};
            txData = i[0] ? 8'h3c : 8'ha5;
            repeat (4) @(negedge clk_link);
            gateCount = 0;
            gateCountEn = 1'b1;
            i_partner.pulse(1'b0);
            i_partner.send_unit(8'hff, 8, i != 1, ack);
            i_partner.pulse(1'b1);
            gateCountEn = 1'b0;
            // gate runs from the start slot to one slot past the unit, and falls during the stop slot
            check(8'(gateCount), 8'(iab_pkg::FULL_UNIT_BITS + (i != 1) + 4'h2),
                  "pulses");
            check(8'(ack), 8'(i == 2), "ack slot");
            check(i_partner.seen, i == 2 ? 8'hff : txData, "data line");
        end
        $display("master pulses done");
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        repeat (3) @(posedge clk_link);
        @(negedge clk_sys);
        rst_n = 1'b1;
        check(8'(nackReplySelect), 8'(iab_pkg::NACK_RST), "nack at reset");
        check(8'(transferWidth), 8'(iab_pkg::WIDTH_RST), "width at reset");
        repeat (4) @(negedge clk_link);
        t_addressed();
        t_busy();
        t_others();
        t_free();
        t_master();
        conclude();
    end
endmodule

// ==== verif/iab_bus_partner.sv ====
// far-side bus party: start, msb-first units, stop; senses the device ack
// assumes: open-drain data line with pull-up; the bench calls its tasks
`timescale 1ns/100ps
module iab_bus_partner (
    input  wire logic clk_link,
    input  wire logic serialDataPinOe,
    output logic      busStart,
    output logic      busStop,
    output logic      serialDataIn
);
    logic drvLevel = 1'b1;
    logic [7:0] seen = 8'h00; // wired line per data slot, read by the bench
    // wired-and of both parties, a released line reads high
    assign serialDataIn = drvLevel & ~serialDataPinOe;
    initial begin
        busStart = 1'b0;
        busStop  = 1'b0;
    end
    // start or stop pulse for one slot, changed after a falling edge
    task automatic pulse(input logic isStop);
        @(negedge clk_link);
        {busStart, busStop} = {~isStop, isStop};
        @(negedge clk_link);
        {busStart, busStop} = 2'b00;
    endtask
    // n bits msb first, then the line let go for the ack slot
    task automatic send_unit(input logic [7:0] d, input int n, input logic slot,
                             output logic ack);
        ack = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            drvLevel = d[i];
            seen     = {seen[6:0], d[i] & ~serialDataPinOe};
            @(negedge clk_link);
        end
        drvLevel = 1'b1;
        if (slot) begin
            ack = serialDataPinOe;
            @(negedge clk_link);
            ack = ack | serialDataPinOe;
        end
    endtask
endmodule
